//--- verilog/iscal_top.sv
`timescale 1ns/1ns
module iscal_top (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// register port
	input  wire iscal_pkg::iscal_bus_t bus,
	output logic [7:0]                 rdata,
	// conversion stream
	input  wire iscal_pkg::iscal_sample_t  raw,
	output iscal_pkg::iscal_sample_t       cooked,
	// input routing
	output logic [3:0]                 pos_input_sel,
	output logic [3:0]                 neg_input_sel,
	output iscal_pkg::iscal_route_t    pos_route,
	output iscal_pkg::iscal_route_t    neg_route
);
	import iscal_pkg::*;

	localparam logic [7:0] RST_VALS [REG_COUNT] = '{RST_INPUT_SEL, RST_OFS_BYTE, RST_OFS_BYTE,
		RST_OFS_BYTE, RST_GAIN_LOW, RST_GAIN_MID, RST_GAIN_HIGH};

	function automatic iscal_route_t decode_sel(input logic [3:0] code);
		iscal_route_t r;
		r = '0;
		if (code <= SEL_COMMON) begin
			r.pin = 11'(11'h001 << code);
		end
		case (code)
			SEL_TEMP:  r.temp = 1'b1;
			SEL_ASUP:  r.asup = 1'b1;
			SEL_DSUP:  r.dsup = 1'b1;
			SEL_TEST:  r.test = 1'b1;
			SEL_FLOAT: r.float_in = 1'b1;
			default:   r.float_in = 1'b0;
		endcase
		return r;
	endfunction

	// register file, index = address - ADDR_INPUT_SEL
	logic [7:0]   reg_ff [REG_COUNT];
	logic [7:0]   rdata_ff;
	logic [7:0]   nxt_rdata;
	wire          addr_hit;
	wire  [7:0]   reg_idx8;
	wire  [2:0]   reg_idx;

	assign addr_hit = (bus.addr >= ADDR_INPUT_SEL) && (bus.addr <= ADDR_GAIN_HIGH);
	assign reg_idx8 = bus.addr - ADDR_INPUT_SEL;
	assign reg_idx  = reg_idx8[2:0];

	genvar gi;
	generate
		for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
			wire wr_hit;
			assign wr_hit = bus.wr && addr_hit && (reg_idx == 3'(gi));
			always_ff @(posedge clk) begin
				if (rst) begin
					reg_ff[gi] <= RST_VALS[gi];
				end else if (wr_hit) begin
					reg_ff[gi] <= bus.wdata;
				end
			end
		end
	endgenerate

	// unmapped addresses read as zero; data stands one cycle only
	assign nxt_rdata = (bus.rd && addr_hit) ? reg_ff[reg_idx] : 8'h00;

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end
	assign rdata = rdata_ff;

	// calibration words
	wire        [7:0]  sel_byte;
	wire signed [23:0] offset_word;
	wire        [23:0] gain_word;

	assign sel_byte    = reg_ff[0];
	assign offset_word = {reg_ff[3], reg_ff[2], reg_ff[1]};
	assign gain_word   = {reg_ff[6], reg_ff[5], reg_ff[4]};

	// input routing, registered so the switches never see decode glitches
	iscal_route_t nxt_pos_route;
	iscal_route_t nxt_neg_route;
	iscal_route_t pos_route_ff;
	iscal_route_t neg_route_ff;

	assign pos_input_sel = sel_byte[POS_SEL_MSB:POS_SEL_LSB];
	assign neg_input_sel = sel_byte[NEG_SEL_MSB:NEG_SEL_LSB];
	assign nxt_pos_route = decode_sel(pos_input_sel);
	assign nxt_neg_route = decode_sel(neg_input_sel);

	always_ff @(posedge clk) begin
		if (rst) begin
			pos_route_ff <= '0;
			neg_route_ff <= '0;
		end else begin
			pos_route_ff <= nxt_pos_route;
			neg_route_ff <= nxt_neg_route;
		end
	end
	assign pos_route = pos_route_ff;
	assign neg_route = neg_route_ff;

	// stage 1: offset subtraction, 34 bits wide so overflow is visible
	wire signed [33:0] ofs_aligned;
	wire signed [33:0] diff_wide;
	wire signed [31:0] nxt_diff;
	logic signed [31:0] diff_ff;
	logic               s1_valid_ff;

	assign ofs_aligned = 34'(offset_word) <<< OFS_ALIGN_SHIFT;
	assign diff_wide   = 34'(raw.data) - ofs_aligned;
	assign nxt_diff    = (diff_wide > 34'(SAT_MAX)) ? SAT_MAX :
	                     (diff_wide < 34'(SAT_MIN)) ? SAT_MIN : diff_wide[31:0];

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_valid_ff <= 1'b0;
			diff_ff     <= '0;
		end else begin
			s1_valid_ff <= raw.valid;
			diff_ff     <= nxt_diff;
		end
	end

	// stage 2: gain, fixed point with 22 fraction bits
	wire signed [56:0] product;
	wire signed [34:0] scaled;
	wire signed [31:0] nxt_scaled;
	iscal_sample_t     cooked_ff;

	assign product    = 57'(diff_ff) * 57'($signed({1'b0, gain_word}));
	assign scaled     = product[56:GAIN_FRAC_BITS];
	assign nxt_scaled = (scaled > 35'(SAT_MAX)) ? SAT_MAX :
	                    (scaled < 35'(SAT_MIN)) ? SAT_MIN : scaled[31:0];

	always_ff @(posedge clk) begin
		if (rst) begin
			cooked_ff <= '0;
		end else begin
			cooked_ff.valid <= s1_valid_ff;
			cooked_ff.data  <= nxt_scaled;
		end
	end
	assign cooked = cooked_ff;

	// checks
	a_pos_pin_map: assert property (@(posedge clk) disable iff (rst)
		(pos_input_sel <= SEL_COMMON) |=> pos_route.pin == 11'(11'h001 << $past(pos_input_sel)))
		else $error("positive pin route wrong");

	a_pos_monitor: assert property (@(posedge clk) disable iff (rst)
		(pos_input_sel == SEL_TEST) |=> pos_route.test && !pos_route.float_in && pos_route.pin == '0)
		else $error("positive test source route wrong");

	a_pos_float: assert property (@(posedge clk) disable iff (rst)
		(pos_input_sel == SEL_FLOAT) |=> pos_route == 16'h0001)
		else $error("positive float route wrong");

	a_neg_reset_pin: assert property (@(posedge clk)
		rst ##1 !rst |=> neg_route.pin == 11'h002 && pos_route.pin == 11'h001)
		else $error("reset routing not input 0 / input 1");

	a_neg_monitor: assert property (@(posedge clk) disable iff (rst)
		(neg_input_sel == SEL_DSUP) |=> neg_route.dsup && !neg_route.asup && !neg_route.temp)
		else $error("negative digital supply route wrong");

	a_ofs_mid_wr: assert property (@(posedge clk) disable iff (rst)
		(bus.wr && bus.addr == ADDR_OFS_MID) |=> offset_word[15:8] == $past(bus.wdata))
		else $error("offset middle byte not stored");

	a_ofs_read: assert property (@(posedge clk) disable iff (rst)
		(bus.wr && bus.addr == ADDR_OFS_HIGH) ##1 (bus.rd && bus.addr == ADDR_OFS_HIGH && !bus.wr)
		|=> rdata == $past(bus.wdata, 2))
		else $error("offset high byte read-back wrong");

	a_ofs_subtract: assert property (@(posedge clk) disable iff (rst)
		(diff_wide <= 34'(SAT_MAX) && diff_wide >= 34'(SAT_MIN))
		|=> diff_ff == $past(raw.data) - (32'($past(offset_word)) <<< OFS_ALIGN_SHIFT))
		else $error("offset subtraction wrong");

	a_unity_gain: assert property (@(posedge clk) disable iff (rst)
		(gain_word == GAIN_UNITY && s1_valid_ff) |=> cooked.valid && cooked.data == $past(diff_ff))
		else $error("unity gain does not pass result");

	a_double_gain: assert property (@(posedge clk) disable iff (rst)
		(gain_word == 24'h800000 && diff_ff == 32'h00001000) |=> cooked.data == 32'h00002000)
		else $error("gain of two wrong");

	a_gain_reset: assert property (@(posedge clk)
		rst |=> gain_word == GAIN_UNITY && offset_word == '0)
		else $error("calibration reset value wrong");

	a_sat_offset: assert property (@(posedge clk) disable iff (rst)
		(diff_wide > 34'(SAT_MAX)) |=> diff_ff == SAT_MAX)
		else $error("offset step not saturated");

	a_sat_gain: assert property (@(posedge clk) disable iff (rst)
		(scaled < 35'(SAT_MIN)) |=> cooked.data == SAT_MIN)
		else $error("gain step not saturated");

	a_latency: assert property (@(posedge clk) disable iff (rst)
		raw.valid |-> ##2 cooked.valid)
		else $error("result latency not two cycles");

	a_unmapped_rd: assert property (@(posedge clk) disable iff (rst)
		(bus.rd && !addr_hit) |=> rdata == 8'h00)
		else $error("unmapped read not zero");

	a_pos_common: assert property (@(posedge clk) disable iff (rst)
		(pos_input_sel == SEL_COMMON) |=> pos_route == 16'h8000)
		else $error("positive common route wrong");

	a_pos_temp: assert property (@(posedge clk) disable iff (rst)
		(pos_input_sel == SEL_TEMP) |=> pos_route == 16'h0010)
		else $error("positive temperature route wrong");

	a_pos_asup: assert property (@(posedge clk) disable iff (rst)
		(pos_input_sel == SEL_ASUP) |=> pos_route == 16'h0008)
		else $error("positive analog supply route wrong");

	a_pos_dsup: assert property (@(posedge clk) disable iff (rst)
		(pos_input_sel == SEL_DSUP) |=> pos_route == 16'h0004)
		else $error("positive digital supply route wrong");

	a_neg_pin_map: assert property (@(posedge clk) disable iff (rst)
		(neg_input_sel <= SEL_COMMON) |=> neg_route == iscal_route_t'({11'(11'h001 << $past(neg_input_sel)), 5'h00}))
		else $error("negative pin route wrong");

	a_neg_float: assert property (@(posedge clk) disable iff (rst)
		(neg_input_sel == SEL_FLOAT) |=> neg_route == 16'h0001)
		else $error("negative float route wrong");

	a_neg_test: assert property (@(posedge clk) disable iff (rst)
		(neg_input_sel == SEL_TEST) |=> neg_route == 16'h0002)
		else $error("negative test source route wrong");

	a_sel_read: assert property (@(posedge clk) disable iff (rst)
		(bus.rd && bus.addr == ADDR_INPUT_SEL) |=> rdata == {$past(pos_input_sel), $past(neg_input_sel)})
		else $error("selector read-back wrong");

	a_ofs_low_wr: assert property (@(posedge clk) disable iff (rst)
		(bus.wr && bus.addr == ADDR_OFS_LOW) |=> offset_word[7:0] == $past(bus.wdata))
		else $error("offset low byte not stored");

	a_ofs_high_wr: assert property (@(posedge clk) disable iff (rst)
		(bus.wr && bus.addr == ADDR_OFS_HIGH) |=> offset_word[23:16] == $past(bus.wdata))
		else $error("offset high byte not stored");

	a_gain_low_wr: assert property (@(posedge clk) disable iff (rst)
		(bus.wr && bus.addr == ADDR_GAIN_LOW) |=> gain_word[7:0] == $past(bus.wdata))
		else $error("gain low byte not stored");

	a_gain_mid_wr: assert property (@(posedge clk) disable iff (rst)
		(bus.wr && bus.addr == ADDR_GAIN_MID) |=> gain_word[15:8] == $past(bus.wdata))
		else $error("gain middle byte not stored");

	a_gain_high_wr: assert property (@(posedge clk) disable iff (rst)
		(bus.wr && bus.addr == ADDR_GAIN_HIGH) |=> gain_word[23:16] == $past(bus.wdata))
		else $error("gain high byte not stored");

	a_half_gain: assert property (@(posedge clk) disable iff (rst)
		(gain_word == 24'h200000 && s1_valid_ff) |=> cooked.valid && cooked.data == ($past(diff_ff) >>> 1))
		else $error("half gain wrong");

	a_sat_ofs_low: assert property (@(posedge clk) disable iff (rst)
		(diff_wide < 34'(SAT_MIN)) |=> diff_ff == SAT_MIN)
		else $error("offset step not saturated low");

	a_sat_gain_high: assert property (@(posedge clk) disable iff (rst)
		(scaled > 35'(SAT_MAX)) |=> cooked.data == SAT_MAX)
		else $error("gain step not saturated high");

	a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
		!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data not cleared");

	a_no_spurious: assert property (@(posedge clk) disable iff (rst)
		!raw.valid |-> ##2 !cooked.valid)
		else $error("result valid without sample");

endmodule

//--- verilog/iscal_pkg.sv
package iscal_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_INPUT_SEL  = 8'h06;
	localparam logic [7:0] ADDR_OFS_LOW    = 8'h07;
	localparam logic [7:0] ADDR_OFS_MID    = 8'h08;
	localparam logic [7:0] ADDR_OFS_HIGH   = 8'h09;
	localparam logic [7:0] ADDR_GAIN_LOW   = 8'h0A;
	localparam logic [7:0] ADDR_GAIN_MID   = 8'h0B;
	localparam logic [7:0] ADDR_GAIN_HIGH  = 8'h0C;
	localparam int         REG_COUNT       = 7;

	// reset values
	localparam logic [7:0] RST_INPUT_SEL   = 8'h01;
	localparam logic [7:0] RST_OFS_BYTE    = 8'h00;
	localparam logic [7:0] RST_GAIN_LOW    = 8'h00;
	localparam logic [7:0] RST_GAIN_MID    = 8'h00;
	localparam logic [7:0] RST_GAIN_HIGH   = 8'h40;
	localparam logic [23:0] GAIN_UNITY     = 24'h400000;

	// input_select field positions
	localparam int POS_SEL_MSB = 7;
	localparam int POS_SEL_LSB = 4;
	localparam int NEG_SEL_MSB = 3;
	localparam int NEG_SEL_LSB = 0;

	// selector codes
	localparam logic [3:0] SEL_LAST_PIN = 4'h9;
	localparam logic [3:0] SEL_COMMON   = 4'hA;
	localparam logic [3:0] SEL_TEMP     = 4'hB;
	localparam logic [3:0] SEL_ASUP     = 4'hC;
	localparam logic [3:0] SEL_DSUP     = 4'hD;
	localparam logic [3:0] SEL_TEST     = 4'hE;
	localparam logic [3:0] SEL_FLOAT    = 4'hF;

	// datapath alignment
	localparam int OFS_ALIGN_SHIFT  = 8;
	localparam int GAIN_FRAC_BITS   = 22;
	localparam logic signed [31:0] SAT_MAX = 32'h7FFFFFFF;
	localparam logic signed [31:0] SAT_MIN = 32'h80000000;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} iscal_bus_t;

	typedef struct packed {
		logic               valid;
		logic signed [31:0] data;
	} iscal_sample_t;

	// pin[9:0] external inputs, pin[10] common input
	typedef struct packed {
		logic [10:0] pin;
		logic        temp;
		logic        asup;
		logic        dsup;
		logic        test;
		logic        float_in;
	} iscal_route_t;

endpackage

//--- dv/input_select_and_calibration_tb.sv
`timescale 1ns/1ns
module input_select_and_calibration_tb;
	import iscal_pkg::*;

	logic          clk;
	logic          rst;
	iscal_bus_t    bus;
	logic [7:0]    rdata;
	iscal_sample_t raw;
	iscal_sample_t cooked;
	logic [3:0]    pos_input_sel;
	logic [3:0]    neg_input_sel;
	iscal_route_t  pos_route;
	iscal_route_t  neg_route;
	int            miscompares;
	int            checks;

	iscal_top i_dut (
		.clk           (clk),
		.rst           (rst),
		.bus           (bus),
		.rdata         (rdata),
		.raw           (raw),
		.cooked        (cooked),
		.pos_input_sel (pos_input_sel),
		.neg_input_sel (neg_input_sel),
		.pos_route     (pos_route),
		.neg_route     (neg_route)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic results;
		if (miscompares == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	// gap cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		bus <= '0;
		#1 chk(rdata === e, "read data");
		@(posedge clk);
		#1 chk(rdata === 8'h00, "read data not cleared");
		@(posedge clk);
	endtask

	function automatic iscal_route_t route_of(input logic [3:0] c);
		return iscal_route_t'(16'h0001 << ((c <= 4'hA) ? 5 + c : 15 - c));
	endfunction

	function automatic longint sat(input longint v);
		return (v > longint'(SAT_MAX)) ? longint'(SAT_MAX) : (v < longint'(SAT_MIN)) ? longint'(SAT_MIN) : v;
	endfunction

	// wide integer model, so overflow is seen before clamping
	function automatic logic signed [31:0] model(input logic [23:0] o, input logic [23:0] g,
			input logic signed [31:0] d);
		longint diff;
		diff = sat(longint'(d) - (longint'($signed(o)) <<< 8));
		return 32'(sat((diff * longint'({1'b0, g})) >>> 22));
	endfunction

	task automatic xfer(input logic [23:0] o, input logic [23:0] g, input logic signed [31:0] d);
		logic signed [31:0] e;
		e = model(o, g, d);
		wr(ADDR_OFS_LOW, o[7:0]);
		wr(ADDR_OFS_MID, o[15:8]);
		wr(ADDR_OFS_HIGH, o[23:16]);
		wr(ADDR_GAIN_LOW, g[7:0]);
		wr(ADDR_GAIN_MID, g[15:8]);
		wr(ADDR_GAIN_HIGH, g[23:16]);
		raw <= '{valid: 1'b1, data: d};
		@(posedge clk);
		raw <= '{valid: 1'b0, data: 32'h00000000};
		#1 chk(cooked.valid === 1'b0, "early result");
		@(posedge clk);
		#1 chk(cooked.valid === 1'b1 && cooked.data === e, "corrected value");
		@(posedge clk);
		#1 chk(cooked.valid === 1'b0, "result pulse too long");
		@(posedge clk);
	endtask

	task automatic t_reset;
		rd_chk(ADDR_INPUT_SEL, 8'h01);
		rd_chk(ADDR_OFS_LOW, 8'h00);
		rd_chk(ADDR_OFS_MID, 8'h00);
		rd_chk(ADDR_OFS_HIGH, 8'h00);
		rd_chk(ADDR_GAIN_LOW, 8'h00);
		rd_chk(ADDR_GAIN_MID, 8'h00);
		rd_chk(ADDR_GAIN_HIGH, 8'h40);
		chk(pos_route === route_of(4'h0) && neg_route === route_of(4'h1), "reset route");
	endtask

	task automatic t_datapath;
		xfer(24'h000000, 24'h400000, 32'h12345678);
		xfer(24'h000001, 24'h400000, 32'h00001000);
		xfer(24'h000020, 24'h800000, 32'h00003000);
		xfer(24'hFFFFFF, 24'h400000, 32'h7FFFFFFF);
		xfer(24'h000000, 24'h800000, 32'hBFFFFFFF);
		xfer(24'h000000, 24'h200000, 32'hFFFFFFFD);
		xfer(24'h7FFFFF, 24'h400000, 32'h80000000);
		xfer(24'h800000, 24'hC00000, 32'h00000000);
	endtask

	// unmapped neighbours 05 and 0D must stay invisible
	task automatic t_regs;
		logic [7:0] a;
		for (a = 8'h05; a <= 8'h0D; a++) begin
			wr(a, a ^ 8'hA5);
		end
		for (a = 8'h05; a <= 8'h0D; a++) begin
			rd_chk(a, (a >= 8'h06 && a <= 8'h0C) ? (a ^ 8'hA5) : 8'h00);
		end
		// write then read with no gap between the strobes
		bus <= '{wr: 1'b1, rd: 1'b0, addr: ADDR_OFS_HIGH, wdata: 8'h3C};
		@(posedge clk);
		rd_chk(ADDR_OFS_HIGH, 8'h3C);
	endtask

	task automatic t_routes;
		logic [4:0] c;
		for (c = 5'h00; c <= 5'h0F; c++) begin
			wr(ADDR_INPUT_SEL, {c[3:0], ~c[3:0]});
			#1 chk(pos_input_sel === c[3:0] && neg_input_sel === ~c[3:0], "selector fields");
			chk(pos_route === route_of(c[3:0]), "positive route");
			chk(neg_route === route_of(~c[3:0]), "negative route");
			@(posedge clk);
		end
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		results;
	end

	initial begin
		miscompares = 0;
		checks = 0;
		rst = 1'b1;
		bus = '0;
		raw = '0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_datapath;
		t_regs;
		t_routes;
		results;
	end
endmodule
